// ### core/charge_state_flags.sv
// Charge integration, capacity estimates and low capacity warning flags behind an Avalon-MM slave.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
// Function
// - Set first flag when remaining below set level.
// - Clear first flag when remaining above level.
// - Set final flag below final set level.
// - Final set level of minus one disables.
// - Clear final flag above clear level only.
// - Load model zero current, one power.
// - Status bit mirrors load model setting.
// - Discharge threshold 0 to 2000, default 60.
// - Charge threshold up to 2000, default 75.
// - Integrate charge, adjust state of charge.
// - Full charge under load to termination.
// - Provide uncompensated remaining and full values.
// - Impedance from predicted OCV versus loaded voltage.
module charge_state_flags (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic initial_low_capacity_flag_o,
  output logic final_low_capacity_flag_o,
  output logic load_model_status_bit_o
);
  import gauge_pkg::*;

  // Reset synchroniser stages; only the second stage is used by logic.
  // The first stage may go metastable on release, so nothing but the second stage reads it.
  logic rst_meta_q;
  logic rst_sync_q;
  // Configuration registers written by software.
  load_model_type load_model_q;
  logic [15:0] first_set_q;
  logic [15:0] final_set_q;
  logic [15:0] final_clr_q;
  logic [15:0] dsg_thr_q;
  logic [15:0] chg_thr_q;
  logic [15:0] qmax_q;
  // Block state.
  logic [15:0] remain_q;
  logic [15:0] remain_d;
  logic [15:0] impedance_q;
  logic signed [15:0] cur_q;
  logic [15:0] volt_q;
  logic upd_q;
  logic first_q;
  logic final_q;
  // Bus handshake: one wait cycle, then acknowledge.
  logic ack_q;

  // Reset release goes through two flops so deassertion is clean on clock_i.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Address decode as named wires.
  wire req = (read_i || write_i) && !ack_q;
  wire wr_go = write_i && ack_q;
  wire hit_ctrl = address_i == ctrl_off;
  wire hit_first = address_i == first_set_off;
  wire hit_fset = address_i == final_set_off;
  wire hit_fclr = address_i == final_clr_off;
  wire hit_dsg = address_i == dsg_thr_off;
  wire hit_chg = address_i == chg_thr_off;
  wire hit_qmax = address_i == qmax_off;
  wire hit_remain = address_i == remain_off;
  wire hit_sample = address_i == sample_off;
  wire [15:0] wlo = writedata_i[15:0];
  wire [15:0] whi = writedata_i[31:16];
  wire lo_en = &byteenable_i[1:0];
  // Threshold writes above the legal maximum are clamped to it.
  // Clamping keeps a bad write harmless instead of leaving an out of range threshold.
  wire [15:0] wthr = (wlo > thr_max) ? thr_max : wlo;

  // Discharge and charge detection against the programmable thresholds.
  // The magnitude must exceed a threshold; equality counts as rest, not as flow.
  wire signed [16:0] cur_ext = {cur_q[15], cur_q};
  wire [15:0] cur_mag = cur_q[15] ? 16'(-cur_q) : cur_q;
  wire dsg_active = cur_q[15] && (cur_mag > dsg_thr_q);
  wire chg_active = !cur_q[15] && (cur_mag > chg_thr_q);

  // Charge step: current in mA per update taken as mAh; saturate at zero and qmax.
  // Saturation keeps the count from wrapping past empty or climbing above the chemical capacity.
  wire signed [17:0] sum = {2'b00, remain_q} + {cur_ext[16], cur_ext};
  wire [15:0] sum_sat = sum[17] ? 16'h0000 : ((sum[16:0] > {1'b0, qmax_q}) ? qmax_q : sum[15:0]);
  // Noise below both thresholds is not integrated, avoiding drift at rest.
  wire [15:0] integ = (dsg_active || chg_active) ? sum_sat : remain_q;

  // Load loss: a constant-current model charges impedance times current; a constant-power
  // model adds one more impedance to that loss, a coarse stand-in for the full arithmetic.
  wire [31:0] loss_cc = impedance_q * cur_mag;
  wire [31:0] loss_cp = loss_cc + {16'h0000, impedance_q};
  wire [15:0] loss = (load_model_q == const_power) ? loss_cp[25:10] : loss_cc[25:10];
  wire [15:0] full_est = (qmax_q > loss) ? 16'(qmax_q - loss) : 16'h0000;
  wire [15:0] rem_comp = (remain_q > loss) ? 16'(remain_q - loss) : 16'h0000;
  wire [15:0] nom_rem = remain_q;
  wire [15:0] nom_full = qmax_q;
  // Impedance from the predicted open-circuit voltage less the loaded voltage.
  // Predicted open-circuit voltage, captured with each sample.
  logic [15:0] ocv_pred_q;
  // The drop floors at zero so a reading above the prediction never wraps.
  // A negative drop would mean a charging cell, where the impedance is left alone.
  wire [15:0] ocv_drop = (ocv_pred_q > volt_q) ? 16'(ocv_pred_q - volt_q) : 16'h0000;

  // Flag next values, evaluated on every remaining capacity update.
  // The compensated value is compared, since that is what software reads as remaining capacity.
  // A set and a clear can both hit for the final flag when its set level is above its clear level; set is given priority.
  // Equality fails the strict compare against that level, so a value parked on a level keeps the flag steady unless the final set level is above its clear level.
  wire first_set_hit = rem_comp < first_set_q;
  wire first_clr_hit = rem_comp > first_set_q;
  wire final_set_hit = (final_set_q != disabled_level) && (rem_comp < final_set_q);
  wire final_clr_hit = final_q && (rem_comp > final_clr_q);
  wire first_d = first_set_hit ? 1'b1 : (first_clr_hit ? 1'b0 : first_q);
  wire final_d = final_set_hit ? 1'b1 : (final_clr_hit ? 1'b0 : final_q);

  // Remaining capacity: software preload wins, otherwise integrate on a sample.
  always_comb begin
    remain_d = remain_q;
    if (wr_go && hit_remain && lo_en) begin
      remain_d = wlo;
    end else if (upd_q) begin
      remain_d = integ;
    end
  end

  // Status word read back; load model bit mirrors the setting directly.
  wire [31:0] status_w = {27'h0, chg_active, dsg_active, load_model_q == const_power, final_q, first_q};

  // Read mux as a priority chain; unmapped addresses read zero.
  wire [15:0] rd16 = hit_ctrl ? {15'h0, load_model_q == const_power} :
                     hit_first ? first_set_q : hit_fset ? final_set_q : hit_fclr ? final_clr_q :
                     hit_dsg ? dsg_thr_q : hit_chg ? chg_thr_q : hit_qmax ? qmax_q :
                     hit_remain ? rem_comp :
                     (address_i == full_off) ? full_est :
                     (address_i == nom_remain_off) ? nom_rem :
                     (address_i == nom_full_off) ? nom_full :
                     (address_i == impedance_off) ? impedance_q : 16'h0000;
  wire [31:0] rdata = (address_i == status_off) ? status_w : {16'h0000, rd16};

  // Bus handshake and read data.
  // A request is seen with ack low, and waitrequest drops on the following edge for one cycle.
  // Read data is refreshed every cycle, so it is valid at the edge where waitrequest is low.
  // The fixed single wait state trades a little bandwidth for a registered read path.
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ack_q <= 1'b0;
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      waitrequest_o <= !req;
      readdata_o <= rdata;
    end
  end

  // Configuration writes take effect at the edge where waitrequest is low.
  // Writes need both low byte lanes; a partial write is dropped rather than merged.
  // The final set level accepts all ones, which stands for minus one and disables the final flag.
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      load_model_q <= const_current;
      first_set_q <= first_set_rst;
      final_set_q <= final_set_rst;
      final_clr_q <= final_clr_rst;
      dsg_thr_q <= dsg_thr_rst;
      chg_thr_q <= chg_thr_rst;
      qmax_q <= qmax_rst;
    end else if (wr_go && lo_en) begin
      if (hit_ctrl) begin
        load_model_q <= load_model_type'(wlo[0]);
      end else if (hit_first) begin
        first_set_q <= wlo;
      end else if (hit_fset) begin
        final_set_q <= wlo;
      end else if (hit_fclr) begin
        final_clr_q <= wlo;
      end else if (hit_dsg) begin
        dsg_thr_q <= wthr;
      end else if (hit_chg) begin
        chg_thr_q <= wthr;
      end else if (hit_qmax) begin
        qmax_q <= wlo;
      end
    end
  end

  // Measurement sample: signed current in the low half, loaded voltage in the high half.
  // The prediction is a coarse stand-in: the loaded voltage plus a term from the previous current.
  // The update pulse follows the write by one cycle so integration sees the new current.
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cur_q <= 16'sh0000;
      volt_q <= 16'h0000;
      ocv_pred_q <= 16'h0000;
      upd_q <= 1'b0;
    end else begin
      upd_q <= wr_go && hit_sample;
      if (wr_go && hit_sample) begin
        cur_q <= $signed(wlo);
        volt_q <= whi;
        ocv_pred_q <= whi + 16'(cur_mag[15:4]);
      end
    end
  end

  // Capacity, impedance and flags; flags update one cycle after each remaining change.
  // Impedance is only refreshed under discharge load, where the drop is meaningful.
  // A preload to the same value raises no update unless a sample arrived too.
  logic rem_upd_q;
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      remain_q <= remain_rst;
      impedance_q <= 16'h0000;
      rem_upd_q <= 1'b0;
      first_q <= 1'b0;
      final_q <= 1'b0;
    end else begin
      remain_q <= remain_d;
      rem_upd_q <= remain_d != remain_q || upd_q;
      if (upd_q && dsg_active) begin
        impedance_q <= ocv_drop;
      end
      if (rem_upd_q) begin
        first_q <= first_d;
        final_q <= final_d;
      end
    end
  end

  // Flag and status pins from flops.
  // The pins lag the internal flags by one cycle so every output comes straight from a flop.
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      initial_low_capacity_flag_o <= 1'b0;
      final_low_capacity_flag_o <= 1'b0;
      load_model_status_bit_o <= 1'b0;
    end else begin
      initial_low_capacity_flag_o <= first_q;
      final_low_capacity_flag_o <= final_q;
      load_model_status_bit_o <= load_model_q == const_power;
    end
  end

  // Assertions.
  property p_first_set;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_upd_q && first_set_hit |=> first_q;
  endproperty
  a_first_set: assert property (p_first_set) else $error("first flag not set");
  property p_first_clr;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_upd_q && first_clr_hit |=> !first_q;
  endproperty
  a_first_clr: assert property (p_first_clr) else $error("first flag not cleared");
  property p_final_set;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_upd_q && final_set_hit |=> final_q;
  endproperty
  a_final_set: assert property (p_final_set) else $error("final flag not set");
  property p_final_off;
    @(posedge clock_i) disable iff (!rst_sync_q) (final_set_q == disabled_level) && !final_q |=> !final_q;
  endproperty
  a_final_off: assert property (p_final_off) else $error("final flag rose while disabled");
  property p_final_clr;
    @(posedge clock_i) disable iff (!rst_sync_q) $fell(final_q) |-> $past(rem_comp) > $past(final_clr_q);
  endproperty
  a_final_clr: assert property (p_final_clr) else $error("final flag cleared early");
  property p_mirror;
    @(posedge clock_i) disable iff (!rst_sync_q) ##1 load_model_status_bit_o == $past(load_model_q == const_power);
  endproperty
  a_mirror: assert property (p_mirror) else $error("load model bit mismatch");
  property p_thr;
    @(posedge clock_i) disable iff (!rst_sync_q) dsg_thr_q <= thr_max && chg_thr_q <= thr_max;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold beyond limit");
  property p_integ;
    @(posedge clock_i) disable iff (!rst_sync_q) upd_q && !(wr_go && hit_remain) |=> remain_q == $past(integ);
  endproperty
  a_integ: assert property (p_integ) else $error("charge not integrated");
  property p_equal;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_upd_q && rem_comp == first_set_q |=> first_q == $past(first_q);
  endproperty
  a_equal: assert property (p_equal) else $error("equality changed flag");
  c_first: cover property (@(posedge clock_i) $rose(first_q));
  c_final: cover property (@(posedge clock_i) $fell(final_q));
  c_power: cover property (@(posedge clock_i) load_model_q == const_power);
  // Cover: a remaining update while the final flag is disabled.
  c_disabled: cover property (@(posedge clock_i) final_set_q == disabled_level && rem_upd_q);
  // Further checks on the flag path, the pins and the estimates.
  // The final flag may only rise while its set level is not the disabling value.
  property p_final_rise;
    @(posedge clock_i) disable iff (!rst_sync_q) $rose(final_q) |-> $past(final_set_q) != disabled_level;
  endproperty
  a_final_rise: assert property (p_final_rise) else $error("final flag rose while disabled");
  // The final flag stays up until the value rises above the clear level.
  property p_final_hold;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_upd_q && final_q && !(rem_comp > final_clr_q) |=> final_q;
  endproperty
  a_final_hold: assert property (p_final_hold) else $error("final flag dropped below clear level");
  // The first flag pin follows the internal flag one cycle later.
  property p_first_pin;
    @(posedge clock_i) disable iff (!rst_sync_q) initial_low_capacity_flag_o == $past(first_q);
  endproperty
  a_first_pin: assert property (p_first_pin) else $error("first flag pin mismatch");
  // The final flag pin follows the internal flag one cycle later.
  property p_final_pin;
    @(posedge clock_i) disable iff (!rst_sync_q) final_low_capacity_flag_o == $past(final_q);
  endproperty
  a_final_pin: assert property (p_final_pin) else $error("final flag pin mismatch");
  // The constant-current model uses the plain impedance times current loss.
  property p_load_cc;
    @(posedge clock_i) disable iff (!rst_sync_q) load_model_q == const_current |-> loss == loss_cc[25:10];
  endproperty
  a_load_cc: assert property (p_load_cc) else $error("wrong load model in use");
  // The full charge estimate never exceeds the chemical capacity.
  property p_full_cap;
    @(posedge clock_i) disable iff (!rst_sync_q) full_est <= qmax_q;
  endproperty
  a_full_cap: assert property (p_full_cap) else $error("full estimate above capacity");
  // The compensated remaining value never exceeds the uncompensated one.
  property p_rem_comp;
    @(posedge clock_i) disable iff (!rst_sync_q) rem_comp <= nom_rem;
  endproperty
  a_rem_comp: assert property (p_rem_comp) else $error("compensated value above uncompensated");
  // Charge and discharge detection never hold together.
  property p_dir;
    @(posedge clock_i) disable iff (!rst_sync_q) !(dsg_active && chg_active);
  endproperty
  a_dir: assert property (p_dir) else $error("charge and discharge both detected");
endmodule

// ### core/gauge_pkg.sv
// Package with register map, field positions, reset values and types of the charge state flag logic.
package gauge_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] first_set_off = 8'h08;
  localparam logic [7:0] final_set_off = 8'h0C;
  localparam logic [7:0] final_clr_off = 8'h10;
  localparam logic [7:0] dsg_thr_off = 8'h14;
  localparam logic [7:0] chg_thr_off = 8'h18;
  localparam logic [7:0] remain_off = 8'h1C;
  localparam logic [7:0] full_off = 8'h20;
  localparam logic [7:0] nom_remain_off = 8'h24;
  localparam logic [7:0] nom_full_off = 8'h28;
  localparam logic [7:0] qmax_off = 8'h2C;
  localparam logic [7:0] impedance_off = 8'h30;
  localparam logic [7:0] sample_off = 8'h34;
  // Field positions in the status word.
  localparam int first_flag_pos = 0;
  localparam int final_flag_pos = 1;
  localparam int load_model_pos = 2;
  localparam int dsg_active_pos = 3;
  localparam int chg_active_pos = 4;
  // Reset values.
  localparam logic [15:0] first_set_rst = 16'h0096;
  localparam logic [15:0] final_set_rst = 16'h004B;
  localparam logic [15:0] final_clr_rst = 16'h0064;
  localparam logic [15:0] dsg_thr_rst = 16'h003C;
  localparam logic [15:0] chg_thr_rst = 16'h004B;
  localparam logic [15:0] thr_max = 16'h07D0;
  localparam logic [15:0] disabled_level = 16'hFFFF;
  localparam logic [15:0] qmax_rst = 16'h05DC;
  localparam logic [15:0] remain_rst = 16'h03E8;
  localparam logic [15:0] reserve_mah = 16'h0000;
  // Load model encodings.
  typedef enum logic {const_current, const_power} load_model_type;
  // One measurement sample presented by software.
  typedef struct packed {
    logic signed [15:0] current_ma;
    logic [15:0] voltage_mv;
    logic [15:0] ocv_mv;
  } sample_type;
endpackage

// ### bench/host_model.sv
// Avalon-MM host that issues register reads and writes to the gauge.
`timescale 1ns/1ns
module host_model (
  input wire logic clock_i,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  output logic timeout_o
);
  // The bus idles with no request, so nothing reaches the slave during reset.
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'hF;
    timeout_o = 1'b0;
  end
  // Holds the request until waitrequest is sampled low; a lost answer raises a timeout, never a hang.
  task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] r);
    int n;
    n = 0;
    address_o <= a;
    read_o <= rd;
    write_o <= !rd;
    writedata_o <= d;
    byteenable_o <= be;
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    r = readdata_i;
    if (n == 50) begin
      timeout_o <= 1'b1;
    end
    read_o <= 1'b0;
    write_o <= 1'b0;
    // One idle edge keeps the next request from reassigning the strobes in this time step.
    @(posedge clock_i);
  endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the charge state flag logic with an integer reference model.
`timescale 1ns/1ns
module tb;
  import gauge_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] address;
  logic read, write, waitreq, flag1, flag2, ldbit, timeout, f1, f2;
  logic [31:0] wdata, rdata, r0, r1;
  logic [3:0] be;
  logic [15:0] lfsr_q = 16'hBA0F;
  int n_errors = 0;
  int checks = 0;
  int fs1, fs2, fc2;
  int vals [0:11] = '{200, 150, 149, 150, 151, 74, 75, 90, 100, 101, 99, 60};
  logic [7:0] offs [0:5] = '{first_set_off, final_set_off, final_clr_off, dsg_thr_off, chg_thr_off, qmax_off};
  int rsts [0:5] = '{150, 75, 100, 60, 75, 1500};
  charge_state_flags charge_state_flags_inst (.clock_i(clock_i), .resetn_i(resetn_i), .address_i(address),
    .read_i(read), .write_i(write), .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata),
    .waitrequest_o(waitreq), .initial_low_capacity_flag_o(flag1), .final_low_capacity_flag_o(flag2),
    .load_model_status_bit_o(ldbit));
  host_model host_model_inst (.clock_i(clock_i), .readdata_i(rdata), .waitrequest_i(waitreq),
    .address_o(address), .read_o(read), .write_o(write), .writedata_o(wdata), .byteenable_o(be),
    .timeout_o(timeout));
  // Free-running 50 MHz clock.
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  // Sixteen bit shift register that supplies the pseudo-random remaining capacities.
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic results;
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_model_inst.access(1'b0, a, d, 4'hF, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    host_model_inst.access(1'b1, a, 32'h0000_0000, 4'hF, r);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(r & mask, exp);
  endtask
  // Preloads remaining capacity and steps the hysteresis model; equality leaves a flag as it was.
  task automatic set_rem(input int v);
    wr(remain_off, v);
    if (v < fs1) f1 = 1'b1; else if (v > fs1) f1 = 1'b0;
    if (fs2 != 65535 && v < fs2) f2 = 1'b1; else if (f2 && v > fc2) f2 = 1'b0;
    repeat (4) @(posedge clock_i);
    check({30'h0, flag2, flag1}, {30'h0, f2, f1});
    rd_check(status_off, 32'h0000_0003, {30'h0, f2, f1});
  endtask
  // A lost bus answer ends the run through the same report.
  always @(posedge clock_i) begin
    if (timeout === 1'b1) begin
      n_errors++;
      results();
    end
  end
  initial begin
    fs1 = 150;
    fs2 = 75;
    fc2 = 100;
    f1 = 1'b0;
    f2 = 1'b0;
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 6; i++) rd_check(offs[i], 32'h0000_FFFF, rsts[i]);
    rd_check(status_off, 32'h0000_0007, 32'h0000_0000);
    rd_check(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    host_model_inst.access(1'b0, first_set_off, 32'h0000_0010, 4'hC, r0);
    rd_check(first_set_off, 32'h0000_FFFF, 32'h0000_0096);
    wr(dsg_thr_off, 32'h0000_07D1);
    rd_check(dsg_thr_off, 32'h0000_FFFF, 32'h0000_07D0);
    wr(chg_thr_off, 32'h0000_FFFF);
    rd_check(chg_thr_off, 32'h0000_FFFF, 32'h0000_07D0);
    wr(dsg_thr_off, 32'h0000_003C);
    wr(chg_thr_off, 32'h0000_004B);
    wr(qmax_off, 32'h0000_05DC);
    for (int m = 1; m >= 0; m--) begin
      wr(ctrl_off, m);
      repeat (3) @(posedge clock_i);
      check({31'h0, ldbit}, m);
      rd_check(status_off, 32'h0000_0004, m << 2);
    end
    foreach (vals[i]) set_rem(vals[i]);
    for (int i = 0; i < 20; i++) begin
      lfsr_q = lfsr(lfsr_q);
      set_rem(lfsr_q[7:0]);
    end
    set_rem(200);
    wr(final_set_off, 32'h0000_FFFF);
    fs2 = 65535;
    set_rem(10);
    set_rem(500);
    rd(remain_off, r0);
    wr(sample_off, 32'h0E74_000A);
    rd(remain_off, r1);
    check(r1[15:0], r0[15:0]);
    wr(sample_off, 32'h0E74_03E8);
    rd(remain_off, r0);
    check({31'h0, r0[15:0] > r1[15:0]}, 1);
    wr(sample_off, 32'h0E74_FC18);
    rd(remain_off, r1);
    check({31'h0, r1[15:0] < r0[15:0]}, 1);
    rd_check(nom_remain_off, 32'h0000_FFFF, 500);
    rd_check(nom_full_off, 32'h0000_FFFF, 1500);
    rd(impedance_off, r0);
    check({31'h0, r0[15:0] != 16'h0000}, 1);
    rd(full_off, r0);
    check({31'h0, r0[15:0] < 16'h05DC}, 1);
    results();
  end
endmodule
